// *** logic/nor_host_pkg.sv ***
// constants for the parallel nor flash host controller
// assumes a 20 MHz clock; delays are converted to cycles rounding up
`default_nettype none
package nor_host_pkg;
  // ==========================================================================
  // organisation
  localparam int ADDR_W        = 26;               // word address, 1Gb part
  localparam int DATA_W        = 16;
  localparam int BLOCK_WORDS_W = 16;               // 64KW per block
  localparam int PAGE_W        = 4;                // 16 words per page
  localparam int CLK_NS        = 50;
  // ==========================================================================
  // timing in ns, cycle counts rounded up, never below one
  localparam int RESET_LOW_NS        = 500;
  localparam int RESET_TO_READ_NS    = 200;
  localparam int RESET_TO_WRITE_NS   = 200;
  localparam int RANDOM_ACCESS_NS    = 100;
  localparam int PAGE_ACCESS_NS      = 20;
  localparam int WRITE_PULSE_NS      = 50;
  localparam int WRITE_RECOVER_NS    = 50;
  localparam int RESET_LOW_CYC      = (RESET_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int RESET_TO_READ_CYC  = (RESET_TO_READ_NS + CLK_NS - 1) / CLK_NS;
  localparam int RESET_TO_WRITE_CYC = (RESET_TO_WRITE_NS + CLK_NS - 1) / CLK_NS;
  localparam int SYNC_CYC           = 2;  // read data passes two flops before it is used
  localparam int RANDOM_ACCESS_CYC  = (RANDOM_ACCESS_NS + CLK_NS - 1) / CLK_NS + SYNC_CYC;
  localparam int PAGE_ACCESS_CYC    = (PAGE_ACCESS_NS + CLK_NS - 1) / CLK_NS + SYNC_CYC;
  localparam int WRITE_PULSE_CYC    = (WRITE_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int WRITE_RECOVER_CYC  = (WRITE_RECOVER_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W              = 8;
  // ==========================================================================
  typedef enum logic [2:0] {
    ST_RESET = 3'b000,
    ST_WAKE  = 3'b001,
    ST_IDLE  = 3'b010,
    ST_READ  = 3'b011,
    ST_WRLOW = 3'b100,
    ST_WRREC = 3'b101
  } state_t;
endpackage : nor_host_pkg
`default_nettype wire

// *** logic/nor_host.sv ***
// host controller driving an asynchronous parallel nor flash over its pins
// assumes one 20 MHz clock, the flash on the pins, a user that handshakes
// requests with reqValid/reqReady and sees a one-cycle rspValid for reads
//
// Behaviour
// R1 - device array is uniform 64KW blocks; host addresses are flat
// R2 - block n spans n times block size plus in-block offset
// R3 - reads may target array, registers, extended block or query area
// R4 - pages are 16 words; A[3:0] and low byte address pick within page
// R5 - page reads work in extended block and query area too
// R6 - read: address out, select and output strobe low, write strobe high
// R7 - after select rises and falls again, wait full random access time
// R8 - every bus write goes to the command interface only
// R9 - address latched on later falling edge of select or write strobe
// R10 - data latched on first rising edge of select or write strobe
// R11 - output strobe stays high throughout each write cycle
// R12 - write protect low keeps the top or bottom block locked
// R13 - strobe glitches under 3ns are ignored by the device
// R14 - select high in read mode gives standby, data lines float
// R15 - select high during program or erase does not give standby
// R16 - output strobe high floats the data lines
// R17 - reset low deselects the device and floats its outputs
// R18 - after reset release wait reset-to-read and reset-to-write delays
// R19 - device leaves reset in read-array mode, polling register clear
// R20 - reset during program or erase aborts it within abort time
// R21 - width select low means bytes, high means words
// R22 - shared top pin is data 15 in words, low address in bytes
// R23 - open-drain ready/busy low while program or erase runs
// R24 - delays are host clock cycle counts rounded up
`default_nettype none
module nor_host (
  input  wire logic                              clk,
  input  wire logic                              srst,
  // user side
  input  wire logic                              reqValid,
  input  wire logic                              reqWrite,
  input  wire logic [nor_host_pkg::ADDR_W-1:0]   reqAddr,
  input  wire logic [nor_host_pkg::DATA_W-1:0]   reqData,
  input  wire logic                              byteMode,
  input  wire logic                              protectEdge,
  input  wire logic                              resetReq,
  output logic                                   reqReady,
  output logic                                   rspValid,
  output logic [nor_host_pkg::DATA_W-1:0]        rspData,
  output logic                                   flashBusy,
  // flash pins
  output logic [nor_host_pkg::ADDR_W-1:0]        flashAddr,
  output logic                                   chipSelN,
  output logic                                   outStrobeN,
  output logic                                   writeStrobeN,
  output logic                                   resetN,
  output logic                                   writeProtN,
  output logic                                   wordSel,
  input  wire logic [nor_host_pkg::DATA_W-2:0]   dataIn,
  output logic [nor_host_pkg::DATA_W-2:0]        dataOut,
  output logic                                   dataOeN,
  input  wire logic                              top_data_or_low_addrIn,
  output logic                                   top_data_or_low_addrOut,
  output logic                                   top_data_or_low_addrOeN,
  input  wire logic                              ready_busy_od
);
  // ==========================================================================
  // input synchronisers
  logic [nor_host_pkg::DATA_W-1:0] dataMeta_ff, dataSync_ff;
  logic                            busyMeta_ff, busySync_ff;

  always_ff @(posedge clk) begin
    dataMeta_ff <= {top_data_or_low_addrIn, dataIn};
    dataSync_ff <= dataMeta_ff;
    busyMeta_ff <= ~ready_busy_od;
    busySync_ff <= busyMeta_ff;
  end

  // ==========================================================================
  // bus sequencer
  nor_host_pkg::state_t            state_ff, nxt_state;
  logic [nor_host_pkg::CNT_W-1:0]  cnt_ff, nxt_cnt;
  logic [nor_host_pkg::CNT_W-1:0]  wakeCnt_ff, nxt_wakeCnt;
  logic                            pageOpen_ff, nxt_pageOpen;
  logic [nor_host_pkg::ADDR_W-nor_host_pkg::PAGE_W-1:0] pageTag_ff, nxt_pageTag;
  logic                            byteMode_ff, nxt_byteMode;
  logic                            isWrite_ff, nxt_isWrite;
  logic [nor_host_pkg::DATA_W-1:0] wrData_ff, nxt_wrData;
  logic [nor_host_pkg::ADDR_W-1:0] addr_ff, nxt_addr;
  logic                            rspValid_ff, nxt_rspValid;
  logic [nor_host_pkg::DATA_W-1:0] rspData_ff, nxt_rspData;
  logic                            reqReady_ff, nxt_reqReady;
  logic                            take;

  localparam logic [nor_host_pkg::CNT_W-1:0] RST_LOW =
    nor_host_pkg::CNT_W'(nor_host_pkg::RESET_LOW_CYC);
  localparam logic [nor_host_pkg::CNT_W-1:0] WAKE_RD =
    nor_host_pkg::CNT_W'(nor_host_pkg::RESET_TO_READ_CYC);
  localparam logic [nor_host_pkg::CNT_W-1:0] WAKE_WR =
    nor_host_pkg::CNT_W'(nor_host_pkg::RESET_TO_WRITE_CYC);
  localparam logic [nor_host_pkg::CNT_W-1:0] RAND_ACC =
    nor_host_pkg::CNT_W'(nor_host_pkg::RANDOM_ACCESS_CYC);
  localparam logic [nor_host_pkg::CNT_W-1:0] PAGE_ACC =
    nor_host_pkg::CNT_W'(nor_host_pkg::PAGE_ACCESS_CYC);
  localparam logic [nor_host_pkg::CNT_W-1:0] WR_PULSE =
    nor_host_pkg::CNT_W'(nor_host_pkg::WRITE_PULSE_CYC);
  localparam logic [nor_host_pkg::CNT_W-1:0] WR_REC =
    nor_host_pkg::CNT_W'(nor_host_pkg::WRITE_RECOVER_CYC);
  localparam logic [nor_host_pkg::CNT_W-1:0] WAKE_MAX = (WAKE_RD > WAKE_WR) ? WAKE_RD : WAKE_WR;

  assign take = reqValid && reqReady_ff;

  always_comb begin
    nxt_state    = state_ff;
    nxt_cnt      = cnt_ff;
    nxt_wakeCnt  = wakeCnt_ff;
    nxt_pageOpen = pageOpen_ff;
    nxt_pageTag  = pageTag_ff;
    nxt_byteMode = byteMode_ff;
    nxt_isWrite  = isWrite_ff;
    nxt_wrData   = wrData_ff;
    nxt_addr     = addr_ff;
    nxt_rspValid = 1'b0;
    nxt_rspData  = rspData_ff;
    nxt_reqReady = 1'b0;
    unique case (state_ff)
      nor_host_pkg::ST_RESET: begin
        // reset pin held low long enough for the device to abort and deselect
        nxt_pageOpen = 1'b0; // see R17
        if (cnt_ff >= RST_LOW && !resetReq) begin // see R20
          nxt_state   = nor_host_pkg::ST_WAKE;
          nxt_wakeCnt = '0;
        end else if (cnt_ff < RST_LOW) begin
          nxt_cnt = cnt_ff + 1'b1;
        end
      end
      nor_host_pkg::ST_WAKE: begin
        // the later of both wake delays covers reads and writes alike
        nxt_wakeCnt = wakeCnt_ff + 1'b1; // see R18, R24
        if (wakeCnt_ff + 1'b1 >= WAKE_MAX) begin
          nxt_state    = nor_host_pkg::ST_IDLE; // see R19
          nxt_reqReady = 1'b1;
        end
      end
      nor_host_pkg::ST_IDLE: begin
        nxt_reqReady = 1'b1;
        if (take) begin
          nxt_reqReady = 1'b0;
          nxt_addr     = reqAddr; // see R2, R3
          nxt_byteMode = byteMode; // see R21
          nxt_isWrite  = reqWrite;
          nxt_wrData   = reqData;
          nxt_cnt      = '0;
          if (reqWrite) begin
            // write strobe falls with select, or after it if a page read left select low: address captured there
            nxt_pageOpen = 1'b0;
            nxt_state    = nor_host_pkg::ST_WRLOW; // see R8, R9
          end else begin
            nxt_state = nor_host_pkg::ST_READ;
            // page timing only while select stayed low and the page is unchanged
            nxt_pageOpen = pageOpen_ff && (byteMode == byteMode_ff) &&
                           (reqAddr[nor_host_pkg::ADDR_W-1:nor_host_pkg::PAGE_W] == pageTag_ff); // see R4, R7
            nxt_pageTag = reqAddr[nor_host_pkg::ADDR_W-1:nor_host_pkg::PAGE_W];
          end
        end else begin
          // dropping select ends the page; next read is a random access
          nxt_pageOpen = 1'b0; // see R7, R14
        end
        if (resetReq) begin
          nxt_state    = nor_host_pkg::ST_RESET;
          nxt_cnt      = '0;
          nxt_reqReady = 1'b0;
        end
      end
      nor_host_pkg::ST_READ: begin
        nxt_cnt = cnt_ff + 1'b1;
        if (cnt_ff + 1'b1 >= (pageOpen_ff ? PAGE_ACC : RAND_ACC)) begin // see R4, R5, R7
          nxt_rspValid = 1'b1;
          nxt_rspData  = byteMode_ff ? {8'h00, dataSync_ff[7:0]} : dataSync_ff; // see R22
          nxt_pageOpen = 1'b1;
          nxt_state    = nor_host_pkg::ST_IDLE;
          nxt_reqReady = 1'b1;
        end
      end
      nor_host_pkg::ST_WRLOW: begin
        nxt_cnt = cnt_ff + 1'b1;
        if (cnt_ff + 1'b1 >= WR_PULSE) begin
          // the write strobe rises first, capturing data while select stays low
          nxt_state = nor_host_pkg::ST_WRREC; // see R10
          nxt_cnt   = '0;
        end
      end
      nor_host_pkg::ST_WRREC: begin
        nxt_cnt = cnt_ff + 1'b1;
        if (cnt_ff + 1'b1 >= WR_REC) begin
          nxt_state    = nor_host_pkg::ST_IDLE;
          nxt_reqReady = 1'b1;
        end
      end
      default: begin
        nxt_state = nor_host_pkg::ST_RESET;
        nxt_cnt   = '0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_ff    <= nor_host_pkg::ST_RESET;
      cnt_ff      <= '0;
      wakeCnt_ff  <= '0;
      pageOpen_ff <= 1'b0;
      pageTag_ff  <= '0;
      byteMode_ff <= 1'b0;
      isWrite_ff  <= 1'b0;
      wrData_ff   <= '0;
      addr_ff     <= '0;
      rspValid_ff <= 1'b0;
      rspData_ff  <= '0;
      reqReady_ff <= 1'b0;
    end else begin
      state_ff    <= nxt_state;
      cnt_ff      <= nxt_cnt;
      wakeCnt_ff  <= nxt_wakeCnt;
      pageOpen_ff <= nxt_pageOpen;
      pageTag_ff  <= nxt_pageTag;
      byteMode_ff <= nxt_byteMode;
      isWrite_ff  <= nxt_isWrite;
      wrData_ff   <= nxt_wrData;
      addr_ff     <= nxt_addr;
      rspValid_ff <= nxt_rspValid;
      rspData_ff  <= nxt_rspData;
      reqReady_ff <= nxt_reqReady;
    end
  end

  // ==========================================================================
  // pin registers: every strobe is a whole clock wide, far above glitch length
  logic nxtCs, nxtOe, nxtWe, nxtDrive;

  always_comb begin
    nxtCs    = 1'b1;
    nxtOe    = 1'b1;
    nxtWe    = 1'b1;
    nxtDrive = 1'b0;
    unique case (nxt_state)
      nor_host_pkg::ST_READ: begin
        nxtCs = 1'b0; // see R6, R13
        nxtOe = 1'b0;
      end
      nor_host_pkg::ST_WRLOW: begin
        nxtCs    = 1'b0; // see R11
        nxtWe    = 1'b0;
        nxtDrive = 1'b1;
      end
      nor_host_pkg::ST_WRREC: begin
        // select released one clock after the write strobe, data held over it
        nxtCs    = (nxt_cnt != '0);
        nxtDrive = 1'b1;
      end
      default: begin
        nxtCs = ~nxt_pageOpen; // see R7
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      chipSelN                <= 1'b1;
      outStrobeN              <= 1'b1;
      writeStrobeN            <= 1'b1;
      resetN                  <= 1'b0;
      writeProtN              <= 1'b0;
      wordSel                 <= 1'b1;
      flashAddr               <= '0;
      dataOut                 <= '0;
      dataOeN                 <= 1'b1;
      top_data_or_low_addrOut <= 1'b0;
      top_data_or_low_addrOeN <= 1'b1;
      flashBusy               <= 1'b0;
      reqReady                <= 1'b0;
      rspValid                <= 1'b0;
      rspData                 <= '0;
    end else begin
      chipSelN     <= nxtCs;
      outStrobeN   <= nxtOe;
      writeStrobeN <= nxtWe;
      resetN       <= (nxt_state != nor_host_pkg::ST_RESET); // see R17, R20
      writeProtN   <= ~protectEdge; // see R12
      wordSel      <= ~nxt_byteMode; // see R21
      // byte mode: request address shifts down one bit, low bit rides on the shared pin
      flashAddr    <= nxt_byteMode ? {1'b0, nxt_addr[nor_host_pkg::ADDR_W-1:1]} : nxt_addr; // see R22
      dataOut      <= nxt_wrData[nor_host_pkg::DATA_W-2:0];
      dataOeN      <= ~nxtDrive;
      top_data_or_low_addrOut <= nxt_byteMode ? nxt_addr[0] : nxt_wrData[nor_host_pkg::DATA_W-1];
      top_data_or_low_addrOeN <= ~(nxt_byteMode || nxtDrive);
      flashBusy    <= busySync_ff; // see R15, R23
      reqReady     <= nxt_reqReady;
      rspValid     <= nxt_rspValid;
      rspData      <= nxt_rspData;
    end
  end
endmodule : nor_host
`default_nettype wire

// *** verif/nor_host_sva.sv ***
// pin-level timing checks for the nor host controller
// assumes it is bound onto nor_host and sees only its ports
`default_nettype none
module nor_host_sva (
  input wire logic clk,
  input wire logic srst,
  input wire logic reqReady,
  input wire logic rspValid,
  input wire logic flashBusy,
  input wire logic chipSelN,
  input wire logic outStrobeN,
  input wire logic writeStrobeN,
  input wire logic resetN,
  input wire logic dataOeN,
  input wire logic wordSel,
  input wire logic top_data_or_low_addrOeN,
  input wire logic ready_busy_od
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // ==========================================================================
  // strobes
  read_ctrl_a: assert property (!outStrobeN |-> writeStrobeN && !chipSelN) else $error("read strobes");
  write_oe_a: assert property (!writeStrobeN |-> outStrobeN && !chipSelN) else $error("write strobes");
  data_edge_a: assert property ($rose(writeStrobeN) |-> !chipSelN ##1 chipSelN) else $error("edge order");
  wr_drive_a: assert property (!writeStrobeN |-> !dataOeN) else $error("write data");
  rd_float_a: assert property (!outStrobeN |-> dataOeN) else $error("bus fight");
  random_gap_a: assert property ($fell(chipSelN) |-> !rspValid [*3]) else $error("early data");
  rsp_time_a: assert property (rspValid |-> outStrobeN && !$past(outStrobeN)) else $error("rsp");
  byte_pin_a: assert property (!wordSel |-> !top_data_or_low_addrOeN) else $error("pin");
  // ==========================================================================
  // reset and busy
  reset_hold_a: assert property ($fell(srst) |-> (!resetN && chipSelN && outStrobeN) [*8])
    else $error("reset pins");
  wake_wait_a: assert property ($rose(resetN) |-> !reqReady [*4]) else $error("wake");
  busy_sync_a: assert property ($fell(ready_busy_od) |-> ##[1:3] flashBusy) else $error("busy");
endmodule : nor_host_sva
bind nor_host nor_host_sva u_sva (.clk(clk), .srst(srst), .reqReady(reqReady), .rspValid(rspValid),
  .flashBusy(flashBusy), .chipSelN(chipSelN), .outStrobeN(outStrobeN), .writeStrobeN(writeStrobeN),
  .resetN(resetN), .dataOeN(dataOeN), .wordSel(wordSel), .top_data_or_low_addrOeN(top_data_or_low_addrOeN),
  .ready_busy_od(ready_busy_od));
`default_nettype wire

// *** verif/nor_flash_model.sv ***
// behavioural flash device on the far side of the pins
// assumes the bench resolves shared data lines; array content is a fixed pattern
`default_nettype none
module nor_flash_model (
  input  wire logic [25:0] addr,
  input  wire logic        ceN,
  input  wire logic        oeN,
  input  wire logic        weN,
  input  wire logic        rstN,
  input  wire logic        wordSel,
  input  wire logic        lowAddr,
  input  wire logic [15:0] hostDq,
  output logic      [15:0] dq,
  output logic             rbN,
  output logic      [25:0] cmdAddr,
  output logic      [15:0] cmdData
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] word;
  logic [15:0] last = 16'h0000;
  logic [7:0]  byteV;
  logic        readOn;
  logic        late = 1'b0;
  time         selT = 0;
  logic        inWr = 1'b0;
  int          busyT = 0;
  assign word = addr[15:0] ^ {6'h00, addr[25:16]} ^ 16'h5A3C;
  assign byteV = lowAddr ? word[15:8] : word[7:0];
  assign readOn = rstN && !ceN && !oeN && weN;
  // access time counts from select falling; a short deselect still restarts it
  always @(negedge ceN or posedge rstN) selT = $time;
  always #5 late = !ceN && rstN && ($time - selT >= 90);
  always @(posedge late) last <= wordSel ? word : {8'h00, byteV};
  // released lines show the inverse of the last value, not a stale copy
  assign dq[7:0] = (readOn && late) ? (wordSel ? word[7:0] : byteV) : ~last[7:0];
  assign dq[15:8] = (readOn && late && wordSel) ? word[15:8] : ~last[15:8];
  always @(negedge ceN or negedge weN) begin
    #1; // both strobes may fall in one time step: decide once both have settled
    if (!ceN && !weN && rstN) begin
      cmdAddr = addr;
      inWr = 1'b1;
    end
  end
  always @(posedge ceN or posedge weN) if (inWr) begin
    cmdData = hostDq;
    inWr = 1'b0;
    busyT = 40;
  end
  always begin
    #50;
    if (!rstN) busyT = 0;
    else if (busyT > 0) busyT--;
  end
  assign rbN = (busyT == 0);
endmodule : nor_flash_model
`default_nettype wire

// *** verif/parallel_nor_bus_interface_bench.sv ***
// self-checking bench for the nor host controller
// assumes nor_host, its package, the flash model and the bound checker
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin err_total++; \
  $display("mismatch t=%0t got %0h exp %0h", $time, g, e); end end
module parallel_nor_bus_interface_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, srst = 1'b1, reqValid = 1'b0, reqWrite = 1'b0, byteMode = 1'b0;
  logic protectEdge = 1'b0, resetReq = 1'b0, reqReady, rspValid, flashBusy, chipSelN, outStrobeN;
  logic writeStrobeN, resetN, writeProtN, wordSel, dataOeN, topIn, topOut, topOeN, rbN;
  logic [25:0] reqAddr = 26'h0000000, flashAddr, cmdAddr;
  logic [15:0] reqData = 16'h0000, rspData, dq, cmdData;
  logic [14:0] dataIn, dataOut;
  int err_total = 0, total_checks = 0, cyc = 0;
  assign dataIn = !dataOeN ? dataOut : dq[14:0];
  assign topIn = !topOeN ? topOut : dq[15];
  nor_host u_dut (.clk(clk), .srst(srst), .reqValid(reqValid), .reqWrite(reqWrite), .reqAddr(reqAddr),
    .reqData(reqData), .byteMode(byteMode), .protectEdge(protectEdge), .resetReq(resetReq),
    .reqReady(reqReady), .rspValid(rspValid), .rspData(rspData), .flashBusy(flashBusy),
    .flashAddr(flashAddr), .chipSelN(chipSelN), .outStrobeN(outStrobeN), .writeStrobeN(writeStrobeN),
    .resetN(resetN), .writeProtN(writeProtN), .wordSel(wordSel), .dataIn(dataIn), .dataOut(dataOut),
    .dataOeN(dataOeN), .top_data_or_low_addrIn(topIn), .top_data_or_low_addrOut(topOut),
    .top_data_or_low_addrOeN(topOeN), .ready_busy_od(rbN));
  nor_flash_model u_flash (.addr(flashAddr), .ceN(chipSelN), .oeN(outStrobeN), .weN(writeStrobeN),
    .rstN(resetN), .wordSel(wordSel), .lowAddr(topIn), .hostDq({topIn, dataIn}), .dq(dq), .rbN(rbN),
    .cmdAddr(cmdAddr), .cmdData(cmdData));
  // ==========================================================================
  // clock, timeout, verdict
  initial forever #25 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : stop_test
  function automatic logic [15:0] pat(input logic [25:0] a);
    return a[15:0] ^ {6'h00, a[25:16]} ^ 16'h5A3C;
  endfunction : pat
  // ==========================================================================
  // bus tasks
  task automatic wait_sig(ref logic s, input logic v, input int lim);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (s !== v && n < lim);
  endtask : wait_sig
  task automatic do_req(input logic wr, input logic [25:0] a, input logic [15:0] d);
    @(posedge clk);
    reqValid <= 1'b1;
    reqWrite <= wr;
    reqAddr <= a;
    reqData <= d;
    wait_sig(reqReady, 1'b1, 50);
    reqValid <= 1'b0;
  endtask : do_req
  task automatic do_read(input logic [25:0] a, input logic [15:0] e);
    do_req(1'b0, a, 16'h0000);
    wait_sig(rspValid, 1'b1, 20);
    `CHK(rspValid, 1'b1)
    `CHK(rspData, e)
  endtask : do_read
  // ==========================================================================
  // scenarios
  task automatic test_wake();
    int n;
    n = 0;
    while (reqReady !== 1'b1 && n < 100) begin
      @(posedge clk);
      n++;
    end
    `CHK(n >= nor_host_pkg::RESET_LOW_CYC + nor_host_pkg::RESET_TO_READ_CYC, 1'b1)
  endtask : test_wake
  task automatic test_words();
    logic [25:0] ad [6] = '{26'h0000000, 26'h000000F, 26'h0000010, 26'h000FFFF, 26'h0010000, 26'h3FFFFFF};
    foreach (ad[i]) do_read(ad[i], pat(ad[i]));
  endtask : test_words
  task automatic test_page();
    // second read is queued while the first runs, so select never rises between them
    do_req(1'b0, 26'h0000040, 16'h0000);
    do_req(1'b0, 26'h0000041, 16'h0000);
    `CHK(rspData, pat(26'h0000040))
    wait_sig(rspValid, 1'b1, 4);
    `CHK(rspValid, 1'b1)
    `CHK(rspData, pat(26'h0000041))
  endtask : test_page
  task automatic test_bytes();
    logic [25:0] ad [3] = '{26'h0000000, 26'h000001F, 26'h0020001};
    logic [15:0] w;
    byteMode <= 1'b1;
    repeat (3) @(posedge clk);
    foreach (ad[i]) begin
      w = pat(ad[i] >> 1);
      do_read(ad[i], {8'h00, ad[i][0] ? w[15:8] : w[7:0]});
    end
    byteMode <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : test_bytes
  task automatic test_write();
    do_req(1'b1, 26'h0000555, 16'h00AA);
    wait_sig(reqReady, 1'b1, 20);
    `CHK(cmdAddr, 26'h0000555)
    `CHK(cmdData, 16'h00AA)
    wait_sig(flashBusy, 1'b1, 6);
    `CHK(flashBusy, 1'b1)
    wait_sig(flashBusy, 1'b0, 80);
    `CHK(flashBusy, 1'b0)
    do_read(26'h0000555, pat(26'h0000555));
  endtask : test_write
  task automatic test_abort();
    do_req(1'b1, 26'h00002AA, 16'h0055);
    wait_sig(flashBusy, 1'b1, 20);
    resetReq <= 1'b1;
    wait_sig(resetN, 1'b0, 20);
    resetReq <= 1'b0;
    repeat (5) @(posedge clk);
    `CHK(flashBusy, 1'b0)
    wait_sig(reqReady, 1'b1, 60);
    do_read(26'h00002AA, pat(26'h00002AA));
  endtask : test_abort
  task automatic test_protect();
    protectEdge <= 1'b1;
    repeat (3) @(posedge clk);
    `CHK(writeProtN, 1'b0)
    protectEdge <= 1'b0;
    repeat (3) @(posedge clk);
    `CHK(writeProtN, 1'b1)
  endtask : test_protect
  initial begin
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    test_wake();
    test_words();
    test_page();
    test_bytes();
    test_write();
    test_abort();
    test_protect();
    stop_test();
  end
endmodule : parallel_nor_bus_interface_bench
`default_nettype wire
